/* pkg/branch_pkg.sv */
// Package for the conditional relative branch unit: opcodes, field layout, phases.
// Assumes a 16-bit instruction word and a byte-addressed 21-bit program counter.
package branch_pkg;
    localparam int PC_W       = 21;
    localparam int IW_W       = 16;
    localparam int OP_MSB     = 15;
    localparam int OP_LSB     = 8;
    localparam int OFF_MSB    = 7;
    localparam int OFF_LSB    = 0;
    localparam logic [7:0] OP_BR_ZERO_CLEAR  = 8'hE1;
    localparam logic [7:0] OP_BR_CARRY_CLEAR = 8'hE3;
    localparam logic [7:0] OP_BR_OVF_CLEAR   = 8'hE5;
    localparam logic [7:0] OP_BR_NEG_SET     = 8'hE6;
    localparam logic [7:0] OP_BR_NEG_CLEAR   = 8'hE7;
    localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET     = 21'h000000;
    localparam logic [1:0] PHASE_RESET      = 2'h0;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
    typedef enum {ST_EXEC, ST_FLUSH} exec_state_e;

    // Status flags seen by the unit.
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
    } flags_s;
endpackage

/* hdl/cond_branch_unit.sv */
// Conditional relative branch unit: decodes the five short branches and steers the PC.
// Assumes instr_word, flags and pc_in come from logic on clk_sys; one instruction cycle
// is four clk_sys edges (phases Q1..Q4).
`timescale 1ns/10ps
`default_nettype none
module cond_branch_unit (
    input  wire logic                       clk_sys,     // System clock, 100 MHz.
    input  wire logic                       nrst,        // Asynchronous reset, active low.
    input  wire logic [branch_pkg::IW_W-1:0] instr_word, // Instruction word under execution.
    input  wire branch_pkg::flags_s         flags,       // Current status flags.
    input  wire logic [branch_pkg::PC_W-1:0] pc_in,      // Incremented program counter.
    output logic      [branch_pkg::PC_W-1:0] pc_out,     // Branch target for the core.
    output logic                            pc_load,     // Load pc_out into the PC.
    output logic                            flush,       // Second cycle is a no-operation.
    output logic                            is_branch,   // Word decoded as a branch.
    output logic                            instr_done,  // Instruction cycle completed.
    output logic      [1:0]                 phase        // Current phase, 0 means Q1.
);
    import branch_pkg::*;

    phase_e                phase_reg;
    exec_state_e           state_reg;
    exec_state_e           state_next;
    logic [7:0]            opcode_reg;
    logic [7:0]            offset_reg;
    logic                  take_reg;
    logic [PC_W-1:0]       target_reg;
    logic                  load_reg;
    logic                  flush_reg;
    logic                  br_reg;
    logic                  done_reg;

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                   input logic [7:0] off);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-8){off[7]}}, off};
        rel_target = pc + {ext[PC_W-2:0], 1'b0};
    endfunction

    wire [7:0] op_w       = instr_word[OP_MSB:OP_LSB];
    wire       dec_cc     = (opcode_reg == OP_BR_CARRY_CLEAR);
    wire       dec_nc     = (opcode_reg == OP_BR_NEG_CLEAR);
    wire       dec_ns     = (opcode_reg == OP_BR_NEG_SET);
    wire       dec_oc     = (opcode_reg == OP_BR_OVF_CLEAR);
    wire       dec_zc     = (opcode_reg == OP_BR_ZERO_CLEAR);
    wire       dec_any    = dec_cc | dec_nc | dec_ns | dec_oc | dec_zc;
    // Flags are only read, never written, so status is left unchanged.
    wire       cond_met   = (dec_cc & ~flags.carry)
                          | (dec_nc & ~flags.neg)
                          | (dec_ns &  flags.neg)
                          | (dec_oc & ~flags.ovf)
                          | (dec_zc & ~flags.zero);
    wire [PC_W-1:0] tgt_w = rel_target(pc_in, offset_reg);
    wire       at_q4      = (phase_reg == PH_Q4);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_EXEC:  if (at_q4 && take_reg) state_next = ST_FLUSH;
            ST_FLUSH: if (at_q4) state_next = ST_EXEC;
            default:  state_next = ST_EXEC;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= PH_Q1;
            state_reg <= ST_EXEC;
        end else begin
            phase_reg <= phase_e'(phase_reg + 2'h1);
            state_reg <= state_next;
        end
    end

    // Q1 decodes, Q2 reads the literal, Q3 processes, Q4 writes the PC.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            opcode_reg <= 8'h00;
            offset_reg <= 8'h00;
            take_reg   <= 1'b0;
            target_reg <= PC_RESET;
        end else if (state_reg == ST_EXEC) begin
            if (phase_reg == PH_Q1) opcode_reg <= op_w;
            if (phase_reg == PH_Q2) offset_reg <= instr_word[OFF_MSB:OFF_LSB];
            if (phase_reg == PH_Q3) begin
                take_reg   <= cond_met;
                target_reg <= tgt_w;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            load_reg  <= 1'b0;
            flush_reg <= 1'b0;
            br_reg    <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            load_reg  <= (state_reg == ST_EXEC) && at_q4 && take_reg;
            flush_reg <= (state_next == ST_FLUSH);
            br_reg    <= dec_any;
            done_reg  <= at_q4 && (state_next == ST_EXEC);
        end
    end

    assign pc_out     = target_reg;
    assign pc_load    = load_reg;
    assign flush      = flush_reg;
    assign is_branch  = br_reg;
    assign instr_done = done_reg;
    assign phase      = phase_reg;

    property p_load_once;
        @(posedge clk_sys) disable iff (!nrst)
        pc_load |=> !pc_load [*3];
    endproperty
    a_load_once: assert property (p_load_once) else $error("pc_load repeated");

    property p_flush_len;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(flush) |-> flush [*4] ##1 !flush;
    endproperty
    a_flush_len: assert property (p_flush_len) else $error("flush length wrong");

    property p_load_q1;
        @(posedge clk_sys) disable iff (!nrst)
        pc_load |-> phase == 2'h0 && flush;
    endproperty
    a_load_q1: assert property (p_load_q1) else $error("pc_load misplaced");

    property p_cc;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3 && dec_cc)
            |=> take_reg == !$past(flags.carry);
    endproperty
    a_cc: assert property (p_cc) else $error("carry clear decision wrong");

    property p_nc;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3 && dec_nc)
            |=> take_reg == !$past(flags.neg);
    endproperty
    a_nc: assert property (p_nc) else $error("negative clear decision wrong");

    property p_ns;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3 && dec_ns)
            |=> take_reg == $past(flags.neg);
    endproperty
    a_ns: assert property (p_ns) else $error("negative set decision wrong");

    property p_other;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3 && !dec_any) |=> !take_reg;
    endproperty
    a_other: assert property (p_other) else $error("non-branch taken");

    property p_target;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3)
            |=> target_reg == $past(pc_in) + {{(PC_W-9){offset_reg[7]}}, offset_reg, 1'b0};
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");

    property p_notake;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && at_q4 && !take_reg) |=> !flush && !pc_load && instr_done;
    endproperty
    a_notake: assert property (p_notake) else $error("not taken not one cycle");

    property p_taken;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && at_q4 && take_reg)
            |=> pc_load && flush && !instr_done ##4 instr_done && !flush;
    endproperty
    a_taken: assert property (p_taken) else $error("taken branch not two cycles");

    property p_oc;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3 && dec_oc)
            |=> take_reg == !$past(flags.ovf);
    endproperty
    a_oc: assert property (p_oc) else $error("overflow clear decision wrong");

    property p_zc;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3 && dec_zc)
            |=> take_reg == !$past(flags.zero);
    endproperty
    a_zc: assert property (p_zc) else $error("zero clear decision wrong");

    property p_done_once;
        @(posedge clk_sys) disable iff (!nrst)
        instr_done |=> !instr_done [*3];
    endproperty
    a_done_once: assert property (p_done_once) else $error("instr_done not a pulse");

    // The no-op cycle ignores the word, so a branch left on the bus cannot decode twice.
    property p_refuse;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_FLUSH)
            |=> $stable(opcode_reg) && $stable(offset_reg)
                && $stable(take_reg) && $stable(target_reg);
    endproperty
    a_refuse: assert property (p_refuse) else $error("word taken during no-op cycle");

    property p_br_decode;
        @(posedge clk_sys) disable iff (!nrst)
        (state_reg == ST_EXEC && phase_reg == PH_Q3) |-> is_branch == dec_any;
    endproperty
    a_br_decode: assert property (p_br_decode) else $error("branch decode flag wrong");
endmodule
`default_nettype wire

/* sim/conditional_relative_branch_unit_tb_top.sv */
// Self-checking bench for the conditional relative branch unit.
// Assumes the unit counts its own phases from reset release; inputs change at falling edges.
`timescale 1ns/10ps
`default_nettype none
module conditional_relative_branch_unit_tb_top;
    import branch_pkg::*;
    localparam logic [7:0] OPS [5] = '{OP_BR_ZERO_CLEAR, OP_BR_CARRY_CLEAR, OP_BR_OVF_CLEAR,
                                       OP_BR_NEG_SET, OP_BR_NEG_CLEAR};
    localparam int         FBIT [5] = '{1, 0, 2, 3, 3};
    logic                  clk_sys;
    logic                  nrst;
    logic [IW_W-1:0]       instr_word;
    flags_s                flags;
    logic [PC_W-1:0]       pc_in;
    logic [PC_W-1:0]       pc_out;
    logic                  pc_load;
    logic                  flush;
    logic                  is_branch;
    logic                  instr_done;
    logic [1:0]            phase;
    logic [3:0]            f;
    int                    miscompares;
    int                    samples_checked;

    cond_branch_unit dut_u (.clk_sys(clk_sys), .nrst(nrst), .instr_word(instr_word),
        .flags(flags), .pc_in(pc_in), .pc_out(pc_out), .pc_load(pc_load), .flush(flush),
        .is_branch(is_branch), .instr_done(instr_done), .phase(phase));

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    // One instruction from its Q1; the word is swapped for a non-branch after four clocks
    // so that a fall-through is not followed by a second decode of the same branch.
    // Flags flip once Q3 has sampled them, so a late sample shows in the load count.
    task automatic run_one(input logic [7:0] op, input logic [7:0] off, input flags_s fl,
                           input logic take, input logic br);
        logic [PC_W-1:0] target;
        int              loads;
        int              flushes;
        target = pc_in + {{12{off[7]}}, off, 1'b0};
        loads = 0;
        flushes = 0;
        @(negedge clk_sys);
        while (phase !== 2'h0) @(negedge clk_sys);
        instr_word = {op, off};
        flags = fl;
        for (int k = 1; k < 12; k++) begin
            @(negedge clk_sys);
            if (k == 4) instr_word = 16'h0000;
            if (k == 3) flags = flags_s'(~fl);
            if (k == 3) check(pc_out === target, "target not ready in Q4");
            if (pc_load !== 1'b0) loads++;
            if (flush !== 1'b0) flushes++;
            if (pc_load === 1'b1) check(pc_out === target, "branch target wrong");
            if (k == 4) check(is_branch === br, "branch decode wrong");
            if (k == 4) check(instr_done === !take, "done after one cycle");
            if (k == 8 && take) check(instr_done === 1'b1, "done after two cycles");
        end
        check(loads == int'(take), "pc load count wrong");
        check(flushes == (take ? 4 : 0), "no-op cycle length wrong");
        check(is_branch === 1'b0, "stale branch decode");
    endtask

    // Reset lands in Q3 of a branch in flight; all outputs clear and phase restarts at Q1.
    task automatic reset_mid();
        @(negedge clk_sys);
        while (phase !== 2'h0) @(negedge clk_sys);
        instr_word = {OP_BR_NEG_SET, 8'h10};
        flags = flags_s'(4'h8);
        repeat (2) @(negedge clk_sys);
        check(is_branch === 1'b1, "branch not decoded before reset");
        nrst = 1'b0;
        @(negedge clk_sys);
        check({pc_load, flush, is_branch, instr_done, phase} === 6'h00, "reset not clean");
        check(pc_out === PC_RESET, "pc_out not cleared by reset");
        instr_word = 16'h0000;
        nrst = 1'b1;
        @(negedge clk_sys);
        check(phase === 2'h1 && is_branch === 1'b0, "restart after reset wrong");
    endtask

    initial begin
        nrst = 1'b0;
        instr_word = 16'h0000;
        flags = flags_s'(4'h0);
        pc_in = 21'h000100;
        f = 4'h0;
        miscompares = 0;
        samples_checked = 0;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        // Other flags take the opposite value so a wrong flag selection shows.
        for (int i = 0; i < 10; i++) begin
            f = ~{4{i[0]}};
            f[FBIT[i/2]] = i[0];
            pc_in = i[0] ? 21'h1FFF00 : 21'h000100;
            run_one(OPS[i/2], i[0] ? 8'h7F : 8'h80, flags_s'(f), i[0] == (i/2 == 3), 1'b1);
        end
        reset_mid();
        run_one(OP_BR_CARRY_CLEAR, 8'h05, flags_s'(4'h0), 1'b1, 1'b1);
        run_one(8'hE2, 8'h05, flags_s'(4'h0), 1'b0, 1'b0);
        run_one(8'h00, 8'h05, flags_s'(4'h0), 1'b0, 1'b0);
        end_sim();
    end

    initial begin
        #20000;
        miscompares++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
